// ==== core/pobcc_pkg.sv ====
// Shared constants and carrier types of the pixel output control block
package pobcc_pkg;

    // Data widths
    localparam int PIX_W = 24;
    localparam int CTL_W = 3;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] REG_CTRL_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STAT_OFS = 4'h4;

    // Control register fields
    localparam int CTRL_FMT_BIT  = 0;
    localparam int CTRL_EDGE_BIT = 1;
    localparam int CTRL_PIXELS_PER_CLOCK_SELECT_BIT = 2;
    localparam int CTRL_CTL_LSB  = 4;
    localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0006;

    // Status register fields
    localparam int STAT_SYNC_DETECT_OUT_BIT = 0;
    localparam int STAT_RESERVED_TIE_HIGH_INPUT_BIT = 1;
    localparam int STAT_DRV_BIT  = 2;

    // Timing: pixel clock loss detection on the register clock
    localparam int REF_PERIOD_PS = 25000;
    localparam int SYNC_DETECT_OUT_LOSS_NS  = 1000;
    localparam int SYNC_DETECT_OUT_LOSS_CYC = (SYNC_DETECT_OUT_LOSS_NS * 1000) / REF_PERIOD_PS;
    localparam int SYNC_DETECT_OUT_CNT_W    = 6;

    // Output configuration as seen by the pixel clock domain
    typedef struct packed {
        logic             fmt;
        logic             edg;
        logic             pixels_per_clock_select;
        logic [CTL_W-1:0] ctl;
    } pobcc_cfg_type;

    // Incoming recovered video, one pair per pixel clock
    typedef struct packed {
        logic             de;
        logic             hsync;
        logic             vsync;
        logic [PIX_W-1:0] even;
        logic [PIX_W-1:0] odd;
    } pobcc_pix_type;

endpackage

// ==== core/pobcc_sync.sv ====
// Two-flop synchroniser for level signals
`timescale 1ns/1ps
module pobcc_sync
    import pobcc_pkg::*;
#(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         clk_i,   // Destination clock
    input  wire logic         rst_i,   // Synchronous reset, active high
    input  wire logic [W-1:0] d_i,     // Asynchronous level in
    output logic      [W-1:0] q_o      // Synchronised level out
);

    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    always_comb begin
        meta_nxt = rst_i ? RST_VAL : d_i;
        q_nxt    = rst_i ? RST_VAL : meta_r;
    end

    always_ff @(posedge clk_i) begin
        meta_r <= meta_nxt;
        q_r    <= q_nxt;
    end

    assign q_o = q_r;

endmodule // pobcc_sync

// ==== core/pobcc_top.sv ====
// Pixel output port control: blanking, clock format and output drive
//
// Contract
// [RULE1] Active-video flag high in active, low in blank
// [RULE2] Blank time carries only syncs and user controls
// [RULE3] Active time carries only pixel data
// [RULE4] Clock format low: pixel clock runs continuously
// [RULE5] Clock format high: clock only during active video
// [RULE6] Three user controls; first always driven
// [RULE7] Reserved input held high by the system
// [RULE8] All outputs launched on the pixel clock; sync detect is launched on the register clock
// [RULE9] Edge select picks rising or falling launch
// [RULE10] Drive-off low floats outputs except sync detect; code keeps first user control driven too
// [RULE11] Two pixels together, or even then odd
// [RULE12] Clock gating free of glitches
`timescale 1ns/1ps
module pobcc_top
    import pobcc_pkg::*;
(
    input  wire logic              ref_clk_i,          // Register clock
    input  wire logic              sys_rst_i,          // Sync reset, high
    input  wire logic [ADDR_W-1:0] avs_address_i,      // Byte address
    input  wire logic              avs_read_i,         // Read request
    input  wire logic              avs_write_i,        // Write request
    input  wire logic [DATA_W-1:0] avs_writedata_i,    // Write data
    input  wire logic [3:0]        avs_byteenable_i,   // Byte lanes
    output logic      [DATA_W-1:0] avs_readdata_o,     // Read data
    output logic                   avs_waitrequest_o,  // Stall
    input  wire logic              pix_clk_i,          // Recovered clock
    input  wire pobcc_pix_type     pix_in_i,           // Recovered video
    input  wire logic              output_drive_off_n_i,      // Pin
    input  wire logic              reserved_tie_high_input_i, // Pin
    output logic                   pixel_out_clock_o,  // Pixel clock out
    output logic                   active_video_flag_o,// Active video
    output logic                   hsync_o,            // Line sync
    output logic                   vsync_o,            // Frame sync
    output logic [PIX_W-1:0]       even_pixel_bus_o,   // Even pixels
    output logic [PIX_W-1:0]       odd_pixel_bus_o,    // Odd pixels
    output logic                   pix_oe_o,           // Enable, video pins
    output logic [CTL_W-1:0]       user_control_out_o, // User controls
    output logic [CTL_W-1:0]       user_control_oe_o,  // Enable, controls
    output logic                   sync_detect_out_o   // Pixel clock seen
);

    ////////////////////////////////////////////////////////////////////
    // Register clock domain: bus slave

    logic [DATA_W-1:0] ctrl_r;
    logic [DATA_W-1:0] ctrl_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic              ack_r;
    logic              ack_nxt;
    logic              req;
    logic              sync_detect_out_r;
    logic              sync_detect_out_nxt;
    logic [SYNC_DETECT_OUT_CNT_W-1:0] loss_cnt_r;
    logic [SYNC_DETECT_OUT_CNT_W-1:0] loss_cnt_nxt;
    logic              hb_d_r;
    logic              hb_d_nxt;
    logic [2:0]        ref_pins_s;
    logic              hb_r;

    assign req = avs_read_i | avs_write_i;
    // Every access takes exactly one wait cycle
    assign avs_waitrequest_o = req & ~ack_r;
    assign avs_readdata_o    = rdata_r;

    always_comb begin
        ctrl_nxt  = ctrl_r;
        rdata_nxt = rdata_r;
        ack_nxt   = req & ~ack_r;
        if (avs_write_i && ack_r && avs_address_i == REG_CTRL_OFS &&
            avs_byteenable_i[0]) begin
            ctrl_nxt = {24'h00_0000, 1'b0, avs_writedata_i[6:0]};
        end
        if (avs_read_i && !ack_r) begin
            case (avs_address_i)
                REG_CTRL_OFS: rdata_nxt = ctrl_r;
                REG_STAT_OFS: begin
                    rdata_nxt                = '0;
                    rdata_nxt[STAT_SYNC_DETECT_OUT_BIT] = sync_detect_out_r;
                    rdata_nxt[STAT_RESERVED_TIE_HIGH_INPUT_BIT] = ref_pins_s[1];
                    rdata_nxt[STAT_DRV_BIT]  = ref_pins_s[0];
                end
                default:      rdata_nxt = '0;
            endcase
        end
        if (sys_rst_i) begin
            ctrl_nxt  = CTRL_RST;
            rdata_nxt = '0;
            ack_nxt   = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        ctrl_r  <= ctrl_nxt;
        rdata_r <= rdata_nxt;
        ack_r   <= ack_nxt;
    end

    a_bus_one_wait: assert property (@(posedge ref_clk_i) disable iff
        (sys_rst_i) (req && avs_waitrequest_o) |=> !avs_waitrequest_o)
        else $error("bus access not answered after one wait cycle");

    ////////////////////////////////////////////////////////////////////
    // Register clock domain: pixel clock presence

    pobcc_sync #(.W(3), .RST_VAL(3'b000)) u_ref_sync (
        .clk_i (ref_clk_i),
        .rst_i (sys_rst_i),
        .d_i   ({hb_r, reserved_tie_high_input_i, output_drive_off_n_i}),
        .q_o   (ref_pins_s)
    );

    // A stopped pixel clock freezes the heartbeat, so detect loses it
    always_comb begin
        hb_d_nxt     = ref_pins_s[2];
        loss_cnt_nxt = loss_cnt_r;
        sync_detect_out_nxt     = sync_detect_out_r;
        if (ref_pins_s[2] != hb_d_r) begin
            loss_cnt_nxt = '0;
            sync_detect_out_nxt     = 1'b1;
        end else if (loss_cnt_r == SYNC_DETECT_OUT_CNT_W'(SYNC_DETECT_OUT_LOSS_CYC - 1)) begin
            sync_detect_out_nxt = 1'b0;
        end else begin
            loss_cnt_nxt = loss_cnt_r + 1'b1;
        end
        if (sys_rst_i) begin
            hb_d_nxt     = 1'b0;
            loss_cnt_nxt = '0;
            sync_detect_out_nxt     = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        hb_d_r     <= hb_d_nxt;
        loss_cnt_r <= loss_cnt_nxt;
        sync_detect_out_r     <= sync_detect_out_nxt;
    end

    // Sync detect stays driven whatever the drive-off pin says
    assign sync_detect_out_o = sync_detect_out_r; // [RULE10]

    ////////////////////////////////////////////////////////////////////
    // Pixel clock domain: crossings

    logic          pix_rst;
    logic [5:0]    cfg_vec;
    pobcc_cfg_type cfg_s;
    logic [1:0]    pin_s;
    logic          drv_on_s;
    logic          reserved_tie_high_input_s;

    pobcc_sync #(.W(1), .RST_VAL(1'b1)) u_rst_sync (
        .clk_i (pix_clk_i),
        .rst_i (1'b0),
        .d_i   (sys_rst_i),
        .q_o   (pix_rst)
    );

    // Configuration is static in use; a change lands within two clocks
    pobcc_sync #(.W(6), .RST_VAL(6'h06 << 3)) u_cfg_sync (
        .clk_i (pix_clk_i),
        .rst_i (pix_rst),
        .d_i   ({ctrl_r[CTRL_FMT_BIT], ctrl_r[CTRL_EDGE_BIT],
                 ctrl_r[CTRL_PIXELS_PER_CLOCK_SELECT_BIT], ctrl_r[CTRL_CTL_LSB +: CTL_W]}),
        .q_o   (cfg_vec)
    );
    assign cfg_s = pobcc_cfg_type'(cfg_vec);

    pobcc_sync #(.W(2), .RST_VAL(2'b00)) u_pin_sync (
        .clk_i (pix_clk_i),
        .rst_i (pix_rst),
        .d_i   ({reserved_tie_high_input_i, output_drive_off_n_i}),
        .q_o   (pin_s)
    );
    assign drv_on_s = pin_s[0];
    assign reserved_tie_high_input_s   = pin_s[1];

    ////////////////////////////////////////////////////////////////////
    // Pixel clock domain: output launch

    logic             act_r;
    logic             act_nxt;
    logic             hs_r;
    logic             hs_nxt;
    logic             vs_r;
    logic             vs_nxt;
    logic [CTL_W-1:0] ctl_r;
    logic [CTL_W-1:0] ctl_nxt;
    logic [PIX_W-1:0] even_r;
    logic [PIX_W-1:0] even_nxt;
    logic [PIX_W-1:0] odd_r;
    logic [PIX_W-1:0] odd_nxt;
    logic [PIX_W-1:0] odd_q_r;
    logic [PIX_W-1:0] odd_q_nxt;
    logic             ph_r;
    logic             ph_nxt;
    logic             oe_r;
    logic             oe_nxt;
    logic             hb_nxt;
    logic             in_act;

    // A low reserved pin keeps the port in blank
    assign in_act = pix_in_i.de & reserved_tie_high_input_s; // [RULE7]

    always_comb begin
        act_nxt   = in_act; // [RULE1]
        hs_nxt    = hs_r;
        vs_nxt    = vs_r;
        ctl_nxt   = ctl_r;
        even_nxt  = '0;
        odd_nxt   = '0;
        odd_q_nxt = odd_q_r;
        ph_nxt    = 1'b0;
        oe_nxt    = drv_on_s; // [RULE10]
        hb_nxt    = ~hb_r;
        if (!in_act) begin
            hs_nxt  = pix_in_i.hsync; // [RULE2]
            vs_nxt  = pix_in_i.vsync;
            ctl_nxt = cfg_s.ctl; // [RULE6]
        end else if (cfg_s.pixels_per_clock_select) begin
            even_nxt = pix_in_i.even; // [RULE3]
            odd_nxt  = pix_in_i.odd; // [RULE11]
        end else if (!ph_r) begin
            even_nxt  = pix_in_i.even; // [RULE11]
            odd_q_nxt = pix_in_i.odd;
            ph_nxt    = 1'b1;
        end else begin
            even_nxt = odd_q_r; // [RULE11]
        end
        if (pix_rst) begin
            act_nxt   = 1'b0;
            hs_nxt    = 1'b0;
            vs_nxt    = 1'b0;
            ctl_nxt   = '0;
            odd_q_nxt = '0;
            oe_nxt    = 1'b0;
            hb_nxt    = 1'b0;
        end
    end

    // Launch on the rising recovered edge; edge select inverts the pin
    always_ff @(posedge pix_clk_i) begin
        act_r   <= act_nxt; // [RULE8]
        hs_r    <= hs_nxt;
        vs_r    <= vs_nxt;
        ctl_r   <= ctl_nxt;
        even_r  <= even_nxt;
        odd_r   <= odd_nxt;
        odd_q_r <= odd_q_nxt;
        ph_r    <= ph_nxt;
        oe_r    <= oe_nxt;
        hb_r    <= hb_nxt;
    end

    assign active_video_flag_o = act_r;
    assign hsync_o             = hs_r;
    assign vsync_o             = vs_r;
    assign even_pixel_bus_o    = even_r;
    assign odd_pixel_bus_o     = odd_r;
    assign user_control_out_o  = ctl_r;
    assign pix_oe_o            = oe_r;
    // First control keeps its driver through output drive-off
    assign user_control_oe_o   = {oe_r, oe_r, 1'b1}; // [RULE6]

    ////////////////////////////////////////////////////////////////////
    // Pixel clock domain: output clock format and gating

    logic gate_en;
    logic gate_n_r;
    logic gate_n_nxt;
    logic gate_p_r;
    logic gate_p_nxt;

    assign gate_en = ~cfg_s.fmt | act_r; // [RULE4] [RULE5]

    // Each enable only changes while its clock phase is low
    always_comb begin
        gate_n_nxt = pix_rst ? 1'b0 : gate_en; // [RULE12]
        gate_p_nxt = pix_rst ? 1'b0 : gate_en;
    end

    always_ff @(negedge pix_clk_i) begin
        gate_n_r <= gate_n_nxt;
    end

    always_ff @(posedge pix_clk_i) begin
        gate_p_r <= gate_p_nxt;
    end

    // Edge select high: data move on the rising pin edge
    assign pixel_out_clock_o = cfg_s.edg ? (pix_clk_i & gate_n_r)
                                         : (~pix_clk_i & gate_p_r); // [RULE9]

    ////////////////////////////////////////////////////////////////////
    // Checks

    a_flag_follows_de: assert property (@(posedge pix_clk_i) disable iff
        (pix_rst) 1'b1 |=> act_r == $past(pix_in_i.de && reserved_tie_high_input_s)) // [RULE1]
        else $error("active flag does not follow incoming enable");

    a_blank_no_pixels: assert property (@(posedge pix_clk_i) disable iff
        (pix_rst) !act_r |-> (even_r == '0 && odd_r == '0)) // [RULE2]
        else $error("pixel bus not cleared in blank");

    a_active_sync_held: assert property (@(posedge pix_clk_i) disable iff
        (pix_rst) (act_r && $past(act_r)) |->
        ($stable(hs_r) && $stable(vs_r) && $stable(ctl_r))) // [RULE3]
        else $error("sync or control moved in active video");

    a_tft_clock_runs: assert property (@(posedge pix_clk_i) disable iff
        (pix_rst) (!cfg_s.fmt ##1 !cfg_s.fmt) |->
        (gate_n_r && gate_p_r)) // [RULE4]
        else $error("clock gated in continuous format");

    a_dstn_clock_held: assert property (@(posedge pix_clk_i) disable iff
        (pix_rst) ((cfg_s.fmt && !act_r) ##1 (cfg_s.fmt && !act_r)) |->
        (!gate_n_r && !gate_p_r)) // [RULE5]
        else $error("clock running in blank with gated format");

    a_drive_off_float: assert property (@(posedge pix_clk_i) disable iff
        (pix_rst) !drv_on_s |=>
        (!pix_oe_o && user_control_oe_o == 3'b001)) // [RULE10]
        else $error("outputs driven during drive-off");

    a_one_ppc_order: assert property (@(posedge pix_clk_i) disable iff
        (pix_rst) (in_act && !cfg_s.pixels_per_clock_select && ph_r) |=>
        (even_r == $past(odd_q_r) && odd_r == '0)) // [RULE11]
        else $error("odd pixel not sent second on even bus");

    a_two_ppc_pair: assert property (@(posedge pix_clk_i) disable iff
        (pix_rst) (in_act && cfg_s.pixels_per_clock_select) |=>
        (even_r == $past(pix_in_i.even) &&
         odd_r == $past(pix_in_i.odd))) // [RULE11]
        else $error("pixel pair not sent together");

endmodule // pobcc_top

// ==== verification/pobcc_src_model.sv ====
// Video source and board pin model feeding the pixel output block
`timescale 1ns/1ps
module pobcc_src_model
    import pobcc_pkg::*;
(
    input  wire logic          pix_clk_i,  // Recovered clock
    input  wire logic          go_i,       // Start one active line
    input  wire logic          pixels_per_clock_select_i,     // 1: two pixels a clock
    input  wire logic [3:0]    len_i,      // Pixel pairs in the line
    output pobcc_pix_type      pix_o,      // Video towards the block
    output logic               reserved_o, // Reserved pin level
    output logic               busy_o,     // Line in progress
    output logic               note_vld_o, // Expected pair valid
    output logic [2*PIX_W-1:0] note_o      // Expected even and odd
);
    int               left;
    logic             second;
    logic [PIX_W-1:0] odd_r;
    logic [PIX_W-1:0] e_v;
    logic [PIX_W-1:0] o_v;

    initial begin
        pix_o = '0;
        reserved_o = 1'b1;
        note_vld_o = 1'b0;
        note_o = '0;
        left = 0;
        second = 1'b0;
        odd_r = '0;
    end

    assign busy_o = left != 0;

    // Syncs and pixels are redrawn at random every cycle, so held or zeroed outputs show
    always @(posedge pix_clk_i) begin
        e_v = PIX_W'($urandom);
        o_v = PIX_W'($urandom);
        pix_o.hsync <= 1'($urandom);
        pix_o.vsync <= 1'($urandom);
        pix_o.even <= e_v;
        pix_o.odd <= o_v;
        pix_o.de <= left > 0;
        note_vld_o <= left > 0;
        if (left > 0) begin
            // One pixel a clock: second cycle of a pair carries junk
            if (!pixels_per_clock_select_i && second) begin
                note_o <= {odd_r, PIX_W'(0)};
            end else begin
                note_o <= {e_v, pixels_per_clock_select_i ? o_v : PIX_W'(0)};
            end
            if (!second) begin
                odd_r <= o_v;
            end
            second <= !pixels_per_clock_select_i && !second;
            left <= left - 1;
        end else if (go_i) begin
            left <= pixels_per_clock_select_i ? int'(len_i) : 2 * int'(len_i);
            second <= 1'b0;
        end
    end
endmodule // pobcc_src_model

// ==== verification/tb_top.sv ====
// Self-checking bench for the pixel output control block
`timescale 1ns/1ps
module tb_top
    import pobcc_pkg::*;
;
    logic              ref_clk_i = 1'b0;
    logic              pix_clk_i = 1'b0;
    logic              sys_rst_i = 1'b1;
    logic [ADDR_W-1:0] avs_address_i = '0;
    logic              avs_read_i = 1'b0;
    logic              avs_write_i = 1'b0;
    logic [DATA_W-1:0] avs_writedata_i = '0;
    logic [3:0]        avs_byteenable_i = '0;
    logic [DATA_W-1:0] avs_readdata_o;
    logic              avs_waitrequest_o;
    pobcc_pix_type     pix_in;
    logic              output_drive_off_n_i = 1'b1;
    logic              reserved;
    logic              pixel_out_clock_o;
    logic              active_video_flag_o;
    logic              hsync_o;
    logic              vsync_o;
    logic [PIX_W-1:0]  even_pixel_bus_o;
    logic [PIX_W-1:0]  odd_pixel_bus_o;
    logic              pix_oe_o;
    logic [CTL_W-1:0]  user_control_out_o;
    logic [CTL_W-1:0]  user_control_oe_o;
    logic              sync_detect_out_o;
    logic              go = 1'b0;
    logic [3:0]        len = 4'h1;
    logic              busy;
    logic              note_vld;
    logic [2*PIX_W-1:0] note;
    logic [2:0]        cfg = 3'h6;
    logic              ck_en = 1'b0;
    logic              last_fl = 1'b0;
    logic              prev_act = 1'b0;
    logic              prev_hs = 1'b0;
    logic              prev_vs = 1'b0;
    int                mismatches = 0;
    int                comparisons = 0;
    int                hs_chg = 0;
    logic [2*PIX_W-1:0] vq[$];
    logic [DATA_W-1:0] rq[$];
    event              rd_ev;

    always #12.5 ref_clk_i = ~ref_clk_i;
    // Link clock starts off-phase so no edge lines up with the bus clock
    initial begin
        #7.3;
        forever #80 pix_clk_i = ~pix_clk_i;
    end

    pobcc_top dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .pix_clk_i(pix_clk_i),
        .pix_in_i(pix_in), .output_drive_off_n_i(output_drive_off_n_i),
        .reserved_tie_high_input_i(reserved),
        .pixel_out_clock_o(pixel_out_clock_o),
        .active_video_flag_o(active_video_flag_o), .hsync_o(hsync_o),
        .vsync_o(vsync_o), .even_pixel_bus_o(even_pixel_bus_o),
        .odd_pixel_bus_o(odd_pixel_bus_o), .pix_oe_o(pix_oe_o),
        .user_control_out_o(user_control_out_o),
        .user_control_oe_o(user_control_oe_o),
        .sync_detect_out_o(sync_detect_out_o));

    pobcc_src_model src (.pix_clk_i(pix_clk_i), .go_i(go),
        .pixels_per_clock_select_i(cfg[2]), .len_i(len), .pix_o(pix_in),
        .reserved_o(reserved), .busy_o(busy), .note_vld_o(note_vld),
        .note_o(note));

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Avalon master: hold until waitrequest is seen low, then release
    task automatic bus_req(input logic rd, input logic [ADDR_W-1:0] a,
                           input logic [DATA_W-1:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        avs_read_i <= rd;
        avs_write_i <= !rd;
        // Waitrequest is sampled on the same edge that completes the access
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        if (avs_waitrequest_o !== 1'b0) begin
            mismatches++;
            end_sim;
        end
        if (rd) begin
            -> rd_ev;
        end
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        rq.push_back(e);
        bus_req(1'b1, a, '0, 4'hf);
    endtask

    always @(rd_ev) chk(avs_readdata_o, rq.pop_front());

    ////////////////////////////////////////////////////////////////////
    always @(posedge pix_clk_i) begin
        if (note_vld) begin
            vq.push_back(note);
        end
    end

    always @(negedge pix_clk_i) begin
        if (pix_oe_o === 1'b1) begin
            if (active_video_flag_o === 1'b1) begin
                chk({even_pixel_bus_o, odd_pixel_bus_o},
                    vq.size() != 0 ? vq.pop_front() : '1);
                if (prev_act) chk({hsync_o, vsync_o}, {prev_hs, prev_vs});
            end else begin
                chk({even_pixel_bus_o, odd_pixel_bus_o}, '0);
                hs_chg += int'(hsync_o !== prev_hs);
            end
        end
        prev_act = active_video_flag_o === 1'b1;
        prev_hs = hsync_o;
        prev_vs = vsync_o;
    end

    // Sample the output clock mid-way through its launch-side phase
    always @(pix_clk_i) begin
        #40;
        if (ck_en && pix_clk_i === cfg[1] && pix_oe_o === 1'b1) begin
            if (active_video_flag_o === last_fl) begin
                chk(pixel_out_clock_o, !cfg[0] || last_fl);
            end
            last_fl = active_video_flag_o;
        end
    end

    task automatic run_cfg(input logic [2:0] c, input logic [CTL_W-1:0] u,
                           input logic [3:0] l);
        int n;
        n = 0;
        ck_en = 1'b0;
        cfg = c;
        bus_req(1'b0, REG_CTRL_OFS, {25'h0, u, 1'b0, c}, 4'h1);
        rd(REG_CTRL_OFS, {25'h0, u, 1'b0, c});
        repeat (6) @(posedge pix_clk_i);
        ck_en = 1'b1;
        chk({pix_oe_o, user_control_oe_o, user_control_out_o}, {4'hf, u});
        len <= l;
        go <= 1'b1;
        @(posedge pix_clk_i);
        go <= 1'b0;
        repeat (2) @(posedge pix_clk_i);
        while (busy && n < 40) begin
            @(posedge pix_clk_i);
            n++;
        end
        if (busy) begin
            mismatches++;
            end_sim;
        end
        repeat (6) @(posedge pix_clk_i);
        chk(vq.size(), 0);
    endtask

    initial begin
        void'($urandom(32'h400b));
        // Reset must span several link clock edges as well
        repeat (24) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        repeat (20) @(posedge pix_clk_i);
        rd(REG_CTRL_OFS, CTRL_RST);
        rd(REG_STAT_OFS, 32'h0000_0007);
        rd(4'h8, '0);
        bus_req(1'b0, REG_STAT_OFS, '1, 4'hf);
        bus_req(1'b0, REG_CTRL_OFS, 32'h0000_0071, 4'he);
        rd(REG_CTRL_OFS, CTRL_RST);
        for (int i = 0; i < 8; i++) begin
            run_cfg(3'(i), 3'($urandom),
                    i < 2 ? 4'h1 : 4'($urandom_range(9, 2)));
        end
        ck_en = 1'b0;
        @(posedge pix_clk_i);
        output_drive_off_n_i <= 1'b0;
        repeat (6) @(posedge pix_clk_i);
        chk({pix_oe_o, user_control_oe_o, sync_detect_out_o}, 5'h03);
        rd(REG_STAT_OFS, 32'h0000_0003);
        @(posedge pix_clk_i);
        output_drive_off_n_i <= 1'b1;
        repeat (6) @(posedge pix_clk_i);
        chk(pix_oe_o, 1'b1);
        chk(hs_chg != 0, 1'b1);
        end_sim;
    end

    initial begin
        #500us;
        mismatches++;
        end_sim;
    end
endmodule // tb_top
